// ===== hdl/ama_pkg.sv
/*
 * Package for the address-move and bitwise-AND decode and execute block.
 * Assumes the surrounding core supplies aligned instruction bytes.
 */
package ama_pkg;
    // Opcode leading bytes and leading-byte mask
    localparam logic [7:0] OP_ADDR_MOVE_HI = 8'h14;
    localparam logic [7:0] OP_ABS_LOAD     = 8'h77;
    localparam logic [7:0] OP_AND_REG_HI   = 8'h28;
    localparam logic [7:0] OP_AND_IMM8_HI  = 8'h18;
    localparam logic [7:0] OP_AND_IMM16    = 8'h7d;
    localparam logic [7:0] OP_AND_MEM      = 8'hd9;
    localparam logic [7:0] OP_AND_SHIFT_HI = 8'h10;
    localparam logic [6:0] LEAD_MASK_E     = 7'h7f;
    // Final and middle nibbles of address moves
    localparam logic [3:0] NIB_LABEL_SLOT0 = 4'h5;
    localparam logic [3:0] NIB_LABEL_SLOT1 = 4'hd;
    localparam logic [3:0] NIB_EXT_FIRST   = 4'h1;
    localparam logic [3:0] NIB_EXT_SECOND  = 4'h9;
    localparam logic [3:0] NIB_EXT_MID     = 4'h1;
    // Field widths, register counts, instruction lengths and reset values
    localparam int ACC_W       = 40;
    localparam int ADR_W       = 16;
    localparam int EXT_W       = 23;
    localparam int N_ACC       = 4;
    localparam int N_TA        = 8;
    localparam int N_EXT       = 16;
    localparam int LEN_TWO     = 2;
    localparam int LEN_THREE   = 3;
    localparam int LEN_FOUR    = 4;
    localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [ADR_W-1:0] TA_RST  = 16'h0000;
    localparam logic [EXT_W-1:0] EXT_RST = 23'h00_0000;

    typedef enum logic [1:0] {
        AMA_IDLE = 2'b00,
        AMA_EXEC = 2'b01
    } ama_state_t;
endpackage

// ===== hdl/ama_and_unit.sv
/*
 * Combinational AND datapath, data-unit and address-unit halves.
 * Assumes operands are already selected by the decoder.
 */
`timescale 1ns/1ps
module ama_and_unit (
    input  wire logic               to_acc,
    input  wire logic [39:0]        opa,
    input  wire logic [39:0]        opb,
    output logic      [39:0]        acc_res,
    output logic      [15:0]        adr_res
);
    always_comb begin
        acc_res = opa & opb;
        adr_res = opa[15:0] & opb[15:0];
        if (!to_acc) begin
            acc_res = '0;
        end
    end
endmodule

// ===== hdl/ama_core.sv
/*
 * Decode and one-cycle execute of address moves and AND forms other than the shift form.
 * Assumes the pipeline presents one whole instruction per valid cycle,
 * and supplies the memory word for the memory form with it.
 */
`timescale 1ns/1ps
module ama_core (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               instr_valid,
    input  wire logic [31:0]        instr_bits,
    input  wire logic               in_repeat,
    input  wire logic [15:0]        mem_word,
    output logic                    instr_done,
    output logic      [2:0]         instr_len,
    output logic                    mem_read,
    output logic                    parallel_ok,
    output logic                    illegal,
    output logic                    ext_first_gen,
    output logic      [5:0]         six_bit_shift_amount,
    output logic      [39:0]        acc_out [4],
    output logic      [15:0]        ta_out  [8],
    output logic      [22:0]        ext_out [16]
);
    typedef struct packed {
        ama_pkg::ama_state_t        state;
        logic                       done;
        logic [2:0]                 len;
        logic                       mrd;
        logic                       par;
        logic                       ill;
        logic                       gen1;
        logic [5:0]                 shamt;
        logic [3:0][39:0]           acc;
        logic [7:0][15:0]           ta;
        logic [15:0][22:0]          ext;
    } ama_st_t;

    ama_st_t st_ff;
    ama_st_t nxt_st;

    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic        dst_acc;
    logic [2:0]  dst_idx;
    logic        src_acc;
    logic [2:0]  src_idx;
    logic [39:0] dst_val;
    logic [39:0] src_val;
    logic [39:0] opa;
    logic [39:0] opb;
    logic        to_acc;
    logic [39:0] acc_res;
    logic [15:0] adr_res;

    assign b0 = instr_bits[31:24];
    assign b1 = instr_bits[23:16];
    assign b2 = instr_bits[15:8];
    assign b3 = instr_bits[7:0];

    // Reads a register by group flag and index
    function automatic logic [39:0] rd_reg(input ama_st_t s, input logic is_acc, input logic [2:0] idx);
        logic [39:0] v;
        v = '0;
        if (is_acc) begin
            v = s.acc[idx[1:0]];
        end else begin
            v = {24'h00_0000, s.ta[idx]};
        end
        return v;
    endfunction

    ama_and_unit u_and (
        .to_acc  (to_acc),
        .opa     (opa),
        .opb     (opb),
        .acc_res (acc_res),
        .adr_res (adr_res)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.mrd = 1'b0;
        nxt_st.ill = 1'b0;
        nxt_st.len = 3'h0;
        nxt_st.par = 1'b0;
        nxt_st.state = ama_pkg::AMA_IDLE;
        dst_acc = 1'b0;
        dst_idx = 3'h0;
        src_acc = 1'b0;
        src_idx = 3'h0;
        opa = '0;
        opb = '0;
        to_acc = 1'b0;
        dst_val = '0;
        src_val = '0;
        if (instr_valid) begin
            // One cycle per form, whether repeated or not
            nxt_st.state = ama_pkg::AMA_EXEC;
            nxt_st.done = 1'b1;
            if (b0[7:1] == ama_pkg::OP_ADDR_MOVE_HI[7:1] &&
                (b2[3:0] == ama_pkg::NIB_LABEL_SLOT0 || b2[3:0] == ama_pkg::NIB_LABEL_SLOT1)) begin
                nxt_st.len = 3'(ama_pkg::LEN_THREE);
                nxt_st.ta[b2[6:4]] = {8'h00, b1};
                nxt_st.par = 1'b0;
            end else if (b0[7:1] == ama_pkg::OP_ADDR_MOVE_HI[7:1] && b1[3:0] == ama_pkg::NIB_EXT_MID &&
                         (b2[3:0] == ama_pkg::NIB_EXT_FIRST || b2[3:0] == ama_pkg::NIB_EXT_SECOND)) begin
                nxt_st.len = 3'(ama_pkg::LEN_THREE);
                nxt_st.par = 1'b1;
                nxt_st.gen1 = (b2[3:0] == ama_pkg::NIB_EXT_FIRST);
                nxt_st.ext[b2[7:4]] = st_ff.ext[b1[7:4]];
            end else if (b0 == ama_pkg::OP_ABS_LOAD) begin
                nxt_st.len = 3'(ama_pkg::LEN_FOUR);
                nxt_st.ta[b3[6:4]] = {b1, b2};
            end else if (b0[7:1] == ama_pkg::OP_AND_REG_HI[7:1]) begin
                nxt_st.len = 3'(ama_pkg::LEN_TWO);
                nxt_st.par = 1'b1;
                src_acc = b1[7];
                src_idx = b1[6:4];
                dst_acc = b1[3];
                dst_idx = b1[2:0];
                dst_val = rd_reg(st_ff, dst_acc, dst_idx);
                src_val = rd_reg(st_ff, src_acc, src_idx);
                opa = dst_val;
                opb = src_val;
            end else if (b0[7:1] == ama_pkg::OP_AND_IMM8_HI[7:1]) begin
                nxt_st.len = 3'(ama_pkg::LEN_THREE);
                nxt_st.par = 1'b1;
                dst_acc = b2[7];
                dst_idx = b2[6:4];
                src_acc = b2[3];
                src_idx = b2[2:0];
                opa = rd_reg(st_ff, src_acc, src_idx);
                opb = {32'h0000_0000, b1};
            end else if (b0 == ama_pkg::OP_AND_IMM16) begin
                nxt_st.len = 3'(ama_pkg::LEN_FOUR);
                dst_acc = b3[7];
                dst_idx = b3[6:4];
                src_acc = b3[3];
                src_idx = b3[2:0];
                opa = rd_reg(st_ff, src_acc, src_idx);
                opb = {24'h00_0000, b1, b2};
            end else if (b0 == ama_pkg::OP_AND_MEM) begin
                nxt_st.len = 3'(ama_pkg::LEN_THREE);
                nxt_st.mrd = 1'b1;
                dst_acc = b2[7];
                dst_idx = b2[6:4];
                src_acc = b2[3];
                src_idx = b2[2:0];
                opa = rd_reg(st_ff, src_acc, src_idx);
                opb = {24'h00_0000, mem_word};
            end else if (b0[7:1] == ama_pkg::OP_AND_SHIFT_HI[7:1] && b1[3:0] == 4'h0) begin
                // Shift tail belongs to the shifter; only recognition and shift amount capture here
                nxt_st.len = 3'(ama_pkg::LEN_THREE);
                nxt_st.par = 1'b1;
                nxt_st.shamt = b2[5:0];
            end else begin
                nxt_st.ill = 1'b1;
                nxt_st.done = 1'b0;
            end
            if (b0 == ama_pkg::OP_AND_IMM16 || b0 == ama_pkg::OP_AND_MEM ||
                b0[7:1] == ama_pkg::OP_AND_REG_HI[7:1] || b0[7:1] == ama_pkg::OP_AND_IMM8_HI[7:1]) begin
                to_acc = dst_acc;
                if (dst_acc) begin
                    nxt_st.acc[dst_idx[1:0]] = acc_res;
                end else begin
                    nxt_st.ta[dst_idx] = adr_res;
                end
            end
        end
        if (!in_repeat && !instr_valid) begin
            nxt_st.gen1 = st_ff.gen1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '{state: ama_pkg::AMA_IDLE, done: 1'b0, len: 3'h0, mrd: 1'b0, par: 1'b0,
                       ill: 1'b0, gen1: 1'b0, shamt: 6'h00,
                       acc: {4{ama_pkg::ACC_RST}}, ta: {8{ama_pkg::TA_RST}}, ext: {16{ama_pkg::EXT_RST}}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign instr_done = st_ff.done;
    assign instr_len = st_ff.len;
    assign mem_read = st_ff.mrd;
    assign parallel_ok = st_ff.par;
    assign illegal = st_ff.ill;
    assign ext_first_gen = st_ff.gen1;
    assign six_bit_shift_amount = st_ff.shamt;

    for (genvar g = 0; g < 16; g++) begin : g_out
        assign ext_out[g] = st_ff.ext[g];
        if (g < 8) begin : g_ta
            assign ta_out[g] = st_ff.ta[g];
        end
        if (g < 4) begin : g_acc
            assign acc_out[g] = st_ff.acc[g];
        end
    end

    property p_one_cycle;
        @(posedge clk) disable iff (!rst_n) instr_valid |=> (instr_done || illegal);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("instruction not done in one cycle");

    property p_abs_len;
        @(posedge clk) disable iff (!rst_n) (instr_valid && b0 == ama_pkg::OP_ABS_LOAD) |=> (instr_len == 3'h4 && !mem_read);
    endproperty
    a_abs_len: assert property (p_abs_len) else $error("absolute load length or access wrong");

    property p_abs_val;
        @(posedge clk) disable iff (!rst_n) (instr_valid && b0 == ama_pkg::OP_ABS_LOAD)
            |=> st_ff.ta[$past(b3[6:4])] == $past(instr_bits[23:8]);
    endproperty
    a_abs_val: assert property (p_abs_val) else $error("absolute constant not loaded");

    property p_mem_read;
        @(posedge clk) disable iff (!rst_n) (instr_valid && b0 == ama_pkg::OP_AND_MEM) |=> (mem_read && instr_len == 3'h3);
    endproperty
    a_mem_read: assert property (p_mem_read) else $error("memory AND did not read");

    property p_imm16_nopar;
        @(posedge clk) disable iff (!rst_n) (instr_valid && b0 == ama_pkg::OP_AND_IMM16) |=> !parallel_ok;
    endproperty
    a_imm16_nopar: assert property (p_imm16_nopar) else $error("halfword AND marked parallel");

    property p_ext_gen;
        @(posedge clk) disable iff (!rst_n) (instr_done && parallel_ok && instr_len == 3'h3 && $past(b0[7:1] == 7'h0a))
            |-> ext_first_gen == ($past(b2[3:0]) == 4'h1);
    endproperty
    a_ext_gen: assert property (p_ext_gen) else $error("generator selection wrong");

    property p_reg_len;
        @(posedge clk) disable iff (!rst_n) (instr_valid && b0[7:1] == 7'h14) |=> (instr_len == 3'h2 && parallel_ok);
    endproperty
    a_reg_len: assert property (p_reg_len) else $error("register AND length wrong");

    property p_shift;
        @(posedge clk) disable iff (!rst_n) (instr_valid && b0[7:1] == 7'h08 && b1[3:0] == 4'h0)
            |=> six_bit_shift_amount == $past(b2[5:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift field not captured");

    c_abs: cover property (@(posedge clk) disable iff (!rst_n) instr_valid && b0 == ama_pkg::OP_ABS_LOAD);
    c_mem: cover property (@(posedge clk) disable iff (!rst_n) mem_read);
    c_ext: cover property (@(posedge clk) disable iff (!rst_n) instr_done && ext_first_gen);
endmodule

// ===== verification/ama_fetch_model.sv
/*
 Fetch side model: presents one whole instruction per request.
 Assumes the caller waits for push to return before the next one.
*/
`timescale 1ns/1ps
module ama_fetch_model (
    input  wire logic        clk,
    output logic             instr_valid,
    output logic [31:0]      instr_bits,
    output logic             in_repeat,
    output logic [15:0]      mem_word
);
    initial begin
        instr_valid = 1'b0;
        instr_bits  = 32'h0000_0000;
        in_repeat   = 1'b0;
        mem_word    = 16'h0000;
    end

    task automatic push(input logic [31:0] b, input logic [15:0] w, input logic rep);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_bits  <= b;
        mem_word    <= w;
        in_repeat   <= rep;
        @(posedge clk);
        instr_valid <= 1'b0;
        // Released lines show inverted data so stale values never match
        instr_bits  <= ~b;
        mem_word    <= ~w;
    endtask
endmodule

// ===== verification/tb_addr_move_and_bitwise_and_ops.sv
/*
 Bench for the address move and AND decoder: random and corner forms.
 Assumes registers reset to zero and results appear one cycle after take.
*/
`timescale 1ns/1ps
module tb_addr_move_and_bitwise_and_ops;
    logic        clk;
    logic        rst_n;
    logic        instr_valid;
    logic [31:0] instr_bits;
    logic        in_repeat;
    logic [15:0] mem_word;
    logic        instr_done;
    logic [2:0]  instr_len;
    logic        mem_read;
    logic        parallel_ok;
    logic        illegal;
    logic        ext_first_gen;
    logic [5:0]  six_bit_shift_amount;
    logic [39:0] acc_out [4];
    logic [15:0] ta_out  [8];
    logic [22:0] ext_out [16];
    logic [39:0] m_acc   [4];
    logic [15:0] m_ta    [8];
    logic [22:0] m_ext   [16];
    logic [31:0] lfsr;
    int          err_total;
    int          total_checks;

    ama_fetch_model fetch (.clk(clk), .instr_valid(instr_valid), .instr_bits(instr_bits),
        .in_repeat(in_repeat), .mem_word(mem_word));

    ama_core dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_bits(instr_bits),
        .in_repeat(in_repeat), .mem_word(mem_word), .instr_done(instr_done), .instr_len(instr_len),
        .mem_read(mem_read), .parallel_ok(parallel_ok), .illegal(illegal), .ext_first_gen(ext_first_gen),
        .six_bit_shift_amount(six_bit_shift_amount), .acc_out(acc_out), .ta_out(ta_out), .ext_out(ext_out));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction

    // Flag bit picks group, low bits index inside it
    function automatic logic [39:0] rd(input logic [3:0] f);
        return f[3] ? m_acc[f[1:0]] : {24'h00_0000, m_ta[f[2:0]]};
    endfunction

    task automatic wr(input logic [3:0] f, input logic [39:0] v);
        if (f[3]) m_acc[f[1:0]] = v;
        else m_ta[f[2:0]] = v[15:0];
    endtask

    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_regs();
        for (int i = 0; i < 4; i++) chk("acc", m_acc[i], acc_out[i]);
        for (int i = 0; i < 8; i++) chk("ta", m_ta[i], ta_out[i]);
        for (int i = 0; i < 16; i++) chk("ext", m_ext[i], ext_out[i]);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Kinds: 0 label, 1 abs, 2 ext copy, 3 reg, 4 byte, 5 halfword, 6 mem, 7 shift, 8 unknown
    task automatic run(input int kind, input logic [31:0] r);
        logic [31:0] b;
        logic [15:0] w;
        logic [3:0]  d;
        logic [3:0]  s;
        logic [3:0]  nib;
        logic [7:0]  e;
        d = r[7:4];
        s = r[11:8];
        w = r[15:0] ^ r[31:16];
        e = {7'h00, r[0]};
        case (kind)
            0: begin
                nib = r[1] ? ama_pkg::NIB_LABEL_SLOT1 : ama_pkg::NIB_LABEL_SLOT0;
                // Trailing byte is junk past a three-byte form
                b = {ama_pkg::OP_ADDR_MOVE_HI | e, r[23:16], 1'b0, d[2:0], nib, r[31:24]};
                m_ta[d[2:0]] = {8'h00, r[23:16]};
            end
            1: begin
                b = {ama_pkg::OP_ABS_LOAD, r[31:16], 1'b0, d[2:0], 4'h0};
                m_ta[d[2:0]] = r[31:16];
            end
            2: begin
                nib = r[1] ? ama_pkg::NIB_EXT_SECOND : ama_pkg::NIB_EXT_FIRST;
                b = {ama_pkg::OP_ADDR_MOVE_HI | e, s, 4'h1, d, nib, r[31:24]};
                m_ext[d] = m_ext[s];
            end
            3: begin
                b = {ama_pkg::OP_AND_REG_HI | e, s, d, 16'h0000};
                wr(d, rd(d) & rd(s));
            end
            4: begin
                b = {ama_pkg::OP_AND_IMM8_HI | e, r[23:16], d, s, 8'h00};
                wr(d, rd(s) & {32'h0000_0000, r[23:16]});
            end
            5: begin
                b = {ama_pkg::OP_AND_IMM16, r[31:16], d, s};
                wr(d, rd(s) & {24'h00_0000, r[31:16]});
            end
            6: begin
                b = {ama_pkg::OP_AND_MEM, r[23:16], d, s, 8'h00};
                wr(d, rd(s) & {24'h00_0000, w});
            end
            7: b = {ama_pkg::OP_AND_SHIFT_HI | e, d, 4'h0, 2'b00, r[29:24], r[23:16]};
            default: b = {8'hff, r[23:0]};
        endcase
        fetch.push(b, w, r[2]);
        #1;
        chk("done", kind != 8, instr_done);
        chk("illegal", kind == 8, illegal);
        if (kind != 8) begin
            chk("len", (kind == 3) ? 2 : (kind == 1 || kind == 5) ? 4 : 3, instr_len);
            chk("par", kind == 2 || kind == 3 || kind == 4 || kind == 7, parallel_ok);
            chk("mrd", kind == 6, mem_read);
        end
        if (kind == 7) chk("shift", r[29:24], six_bit_shift_amount);
        if (kind == 2) chk("gen", !r[1], ext_first_gen);
        chk_regs();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        lfsr = 32'hcfa6a42f;
        err_total = 0;
        total_checks = 0;
        for (int i = 0; i < 4; i++) m_acc[i] = 40'h00_0000_0000;
        for (int i = 0; i < 8; i++) m_ta[i] = 16'h0000;
        for (int i = 0; i < 16; i++) m_ext[i] = 23'h00_0000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk_regs();
        // Corner cases: both slots, max byte, all-ones constant, both generators, max shift
        run(0, 32'h00ff_0000);
        run(0, 32'h00ff_0013);
        run(1, 32'hffff_0020);
        run(2, 32'h0000_0010);
        run(2, 32'h0000_0212);
        run(4, 32'h00ff_0211);
        run(3, 32'h0000_0081);
        run(7, 32'h3f00_0000);
        run(8, 32'h0000_0000);
        $display("test directed done");
        for (int n = 0; n < 300; n++) begin
            lfsr = nxt_rand(lfsr);
            // Loads kept frequent so AND forms see nonzero operands
            run((lfsr[3:0] > 4'd11) ? int'(lfsr[3:0]) - 12 : int'(lfsr[15:12]) % 9, nxt_rand(lfsr));
        end
        $display("test random done");
        conclude();
    end
endmodule
